// *** hw/eqf_pkg.sv ***
/*
 * shared constants and carrier types of the nine-tap equalizer block.
 * assumes a 32-bit classic wishbone register bus and 8-bit two-lane samples.
 */
package eqf_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_STAT  = 8'h04;
   localparam logic [7:0] OFF_SET_A = 8'h40;
   localparam logic [7:0] OFF_SET_B = 8'h80;

   // ==========================================================
   // control and status field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SHARE    = 2;
   localparam int CTRL_MERGE    = 3;
   localparam int CTRL_WSEL_LSB = 4;
   localparam int CTRL_LINK_SC  = 8;
   localparam int CTRL_SGL_IN   = 9;
   localparam int STAT_ACTIVE   = 0;
   localparam int STAT_ILLEGAL  = 1;
   localparam int STAT_FULL     = 2;

   // ==========================================================
   // filter geometry and encodings
   localparam int         N_TAP     = 9;
   localparam logic [3:0] CTR_TAP   = 4'h4;
   localparam int         NC_BITS   = 12;
   localparam int         FRAC_BITS = 16;
   localparam logic [1:0] MODE_OFF  = 2'h0;
   localparam logic [1:0] MODE_ON   = 2'h2;
   localparam logic [2:0] WSEL_MAX  = 3'h6;   // 2^-16 step, 0 means 2^-10
   localparam int         FIFO_DEPTH = 16;

   typedef logic signed [7:0] eqf_smp_t;
   typedef eqf_smp_t [8:0]    eqf_win_t;
   typedef logic [17:0]       eqf_coef_t;
   typedef eqf_coef_t [8:0]   eqf_cset_t;

   typedef struct packed {
      eqf_smp_t a;
      eqf_smp_t b;
   } eqf_samp_t;

   typedef struct packed {
      logic       single_input;
      logic       link_single;
      logic       spare;
      logic [2:0] wsel;
      logic       merge;
      logic       share;
      logic [1:0] mode;
   } eqf_ctrl_t;

   // unity center tap, all other taps zero
   localparam eqf_cset_t CSET_RST = eqf_cset_t'({18'h00000, 18'h00000, 18'h00000, 18'h00000,
      18'h10000, 18'h00000, 18'h00000, 18'h00000, 18'h00000});
   localparam eqf_ctrl_t CTRL_RST = eqf_ctrl_t'(10'h000);

   typedef struct packed {
      eqf_ctrl_t          ctrl;
      eqf_cset_t          coef_a;
      eqf_cset_t          coef_b;
      eqf_win_t           ha;
      eqf_win_t           hb;
      logic [9:0][7:0]    hm;
      eqf_samp_t          raw;
      logic               pend;
      logic               in_rdy;
      logic               ack;
      logic [31:0]        rdat;
      logic               out_vld;
      eqf_samp_t          out_dat;
   } eqf_state_t;

endpackage

// *** hw/eqf_top.sv ***
/*
 * nine-tap equalizer on the two-lane sample path, its register slave and its
 * output fifo. assumes samples and bus share clk_i; the transport side may stall.
 */
// Functional notes
// - dual-channel converter mode: each channel filtered with its own coefficients
// - dual equalization keeps nine programmable coefficients per channel
// - center tap is 18 bits with lsb weight 2^-16
// - non-center taps are 12 bits, lsb weight selectable 2^-10 to 2^-16
// - one common lsb weight setting for all non-center taps
// - single-channel mode: one nine-coefficient set filters the single output
// - time-varying filter only in dual-input single-channel operation, two sets
// - time-varying filter alternates the two sets on every sample
// - each time-varying set has nine taps at equalizer resolutions
// - mode 0 off, 2 on; share/merge 00 dual, 11 single, 01 time-varying
`timescale 1ns/1ps

// ==========================================================
// fifo
module eqf_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   input  wire logic         clk_i,     // system clock
   input  wire logic         rst_i,     // sync reset, high
   input  wire logic         in_vld_i,  // push request
   output logic              in_rdy_o,  // room available
   input  wire logic [W-1:0] in_dat_i,  // push data
   output logic              out_vld_o, // data available
   input  wire logic         out_rdy_i, // pop request
   output logic [W-1:0]      out_dat_o  // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_rdy_o  = cnt_q != (AW+1)'(DEPTH);
   assign out_vld_o = cnt_q != '0;
   assign out_dat_o = mem[rp_q];
   assign push      = in_vld_i && in_rdy_o;
   assign pop       = out_vld_o && out_rdy_i;

   // storage has no reset; the count alone says which words are live
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp_q] <= in_dat_i;
      end
      if (rst_i) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==========================================================
// top
module eqf_top (
   input  wire logic              clk_i,      // 50 MHz clock
   input  wire logic              rst_i,      // sync reset, high
   input  wire logic              wb_cyc_i,   // bus cycle
   input  wire logic              wb_stb_i,   // bus strobe
   input  wire logic              wb_we_i,    // write enable
   input  wire logic [7:0]        wb_adr_i,   // byte address
   input  wire logic [3:0]        wb_sel_i,   // byte enables
   input  wire logic [31:0]       wb_dat_i,   // write data
   output logic [31:0]            wb_dat_o,   // read data
   output logic                   wb_ack_o,   // acknowledge
   input  wire logic              smp_vld_i,  // converter sample valid
   output logic                   smp_rdy_o,  // sample accepted
   input  wire eqf_pkg::eqf_samp_t smp_i,     // a = earlier, b = later
   output logic                   tl_vld_o,   // transport sample valid
   input  wire logic              tl_rdy_i,   // transport ready
   output eqf_pkg::eqf_samp_t     tl_dat_o    // filtered sample pair
);
   eqf_pkg::eqf_state_t s_q;
   eqf_pkg::eqf_state_t s_d;
   eqf_pkg::eqf_samp_t  push_dat;
   eqf_pkg::eqf_samp_t  fifo_dat;
   eqf_pkg::eqf_win_t   win_a;
   eqf_pkg::eqf_win_t   win_b;
   eqf_pkg::eqf_cset_t  set_b;
   logic                fifo_in_rdy;
   logic                fifo_out_vld;
   logic                fifo_pop;
   logic                push;
   logic                accept;
   logic                bus_go;
   logic                mode_on;
   logic                dual_eq;
   logic                single_eq;
   logic                tv_eq;
   logic                active;
   logic                merged;

   // ==========================================================
   // helpers
   function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // taps sit one word apart; addresses past the ninth tap fall through as unmapped
   function automatic logic tap_hit(input logic [7:0] adr, input logic [7:0] base);
      return adr[7:6] == base[7:6] && adr[1:0] == 2'h0 && adr[5:2] < 4'(eqf_pkg::N_TAP);
   endfunction

   function automatic logic signed [31:0] mac(input eqf_pkg::eqf_win_t w,
                                              input eqf_pkg::eqf_cset_t c,
                                              input logic [2:0] ws);
      logic signed [31:0] acc;
      logic signed [31:0] p;
      logic [2:0]         sh;
      acc = 32'(signed'(c[eqf_pkg::CTR_TAP])) * 32'(w[eqf_pkg::CTR_TAP]);
      // non-center products move onto the 2^-16 grid, so one adder serves all weights
      sh  = eqf_pkg::WSEL_MAX - ((ws > eqf_pkg::WSEL_MAX) ? eqf_pkg::WSEL_MAX : ws);
      for (int k = 0; k < eqf_pkg::N_TAP; k++) begin
         if (k != int'(eqf_pkg::CTR_TAP)) begin
            p   = 32'(signed'(c[k][eqf_pkg::NC_BITS-1:0])) * 32'(w[k]);
            acc = acc + (p <<< sh);
         end
      end
      return acc;
   endfunction

   // rounding toward minus infinity, then clip to the sample range
   function automatic eqf_pkg::eqf_smp_t sat8(input logic signed [31:0] acc);
      logic signed [31:0] v;
      v = acc >>> eqf_pkg::FRAC_BITS;
      if (v > 32'sd127) begin
         return 8'h7f;
      end else if (v < -32'sd128) begin
         return 8'h80;
      end
      return v[7:0];
   endfunction

   // ==========================================================
   // mode decode
   // a setting that the link mode does not allow falls back to pass-through
   assign mode_on   = s_q.ctrl.mode == eqf_pkg::MODE_ON;
   assign dual_eq   = mode_on && !s_q.ctrl.share && !s_q.ctrl.merge
                      && !s_q.ctrl.link_single;
   assign single_eq = mode_on && s_q.ctrl.share && s_q.ctrl.merge
                      && s_q.ctrl.link_single;
   assign tv_eq     = mode_on && !s_q.ctrl.share && s_q.ctrl.merge
                      && s_q.ctrl.link_single && !s_q.ctrl.single_input;
   assign active    = dual_eq || single_eq || tv_eq;
   assign merged    = single_eq || tv_eq;

   // ==========================================================
   // datapath: in merged modes lane a is the older sample, window shifted by one
   always_comb begin
      win_a = merged ? s_q.hm[9:1] : s_q.ha;
      win_b = merged ? s_q.hm[8:0] : s_q.hb;
      set_b = single_eq ? s_q.coef_a : s_q.coef_b;
      if (active) begin
         push_dat.a = sat8(mac(win_a, s_q.coef_a, s_q.ctrl.wsel));
         push_dat.b = sat8(mac(win_b, set_b, s_q.ctrl.wsel));
      end else begin
         push_dat = s_q.raw;
      end
   end

   // ack blocks bus_go for a cycle, so a strobe held over the answer is taken once
   assign push     = s_q.pend && fifo_in_rdy;
   assign accept   = smp_vld_i && s_q.in_rdy;
   assign bus_go   = wb_cyc_i && wb_stb_i && !s_q.ack;
   assign fifo_pop = fifo_out_vld && (!s_q.out_vld || tl_rdy_i);

   eqf_fifo #(
      .W     (16),
      .DEPTH (eqf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .in_vld_i  (s_q.pend),
      .in_rdy_o  (fifo_in_rdy),
      .in_dat_i  (push_dat),
      .out_vld_o (fifo_out_vld),
      .out_rdy_i (fifo_pop),
      .out_dat_o (fifo_dat)
   );

   // ==========================================================
   // next state
   always_comb begin
      logic [31:0] m;
      logic [3:0]  t;
      m   = '0;
      t   = wb_adr_i[5:2];
      s_d = s_q;
      if (accept) begin
         s_d.ha  = {s_q.ha[7:0], smp_i.a};
         s_d.hb  = {s_q.hb[7:0], smp_i.b};
         s_d.hm  = {s_q.hm[7:0], smp_i.a, smp_i.b};
         s_d.raw = smp_i;
      end
      // one result in flight; the fifo's room stalls the sample source
      s_d.pend   = accept || (s_q.pend && !push);
      s_d.in_rdy = !s_d.pend;
      s_d.ack    = bus_go;
      s_d.rdat   = '0;
      if (bus_go && !wb_we_i) begin
         if (wb_adr_i == eqf_pkg::OFF_CTRL) begin
            s_d.rdat[9:0] = s_q.ctrl;
         end else if (wb_adr_i == eqf_pkg::OFF_STAT) begin
            s_d.rdat[eqf_pkg::STAT_ACTIVE]  = active;
            s_d.rdat[eqf_pkg::STAT_ILLEGAL] = mode_on && !active;
            s_d.rdat[eqf_pkg::STAT_FULL]    = !fifo_in_rdy;
         end else if (tap_hit(wb_adr_i, eqf_pkg::OFF_SET_A)) begin
            s_d.rdat[17:0] = s_q.coef_a[t];
         end else if (tap_hit(wb_adr_i, eqf_pkg::OFF_SET_B)) begin
            s_d.rdat[17:0] = s_q.coef_b[t];
         end
      end
      if (bus_go && wb_we_i) begin
         if (wb_adr_i == eqf_pkg::OFF_CTRL) begin
            m = wr_merge({22'h0, s_q.ctrl}, wb_dat_i, wb_sel_i);
            s_d.ctrl = m[9:0];
            s_d.ctrl.spare = 1'b0;
            if (m[6:4] > eqf_pkg::WSEL_MAX) begin
               s_d.ctrl.wsel = eqf_pkg::WSEL_MAX;
            end
         end else if (tap_hit(wb_adr_i, eqf_pkg::OFF_SET_A)) begin
            m = wr_merge({14'h0, s_q.coef_a[t]}, wb_dat_i, wb_sel_i);
            s_d.coef_a[t] = (t == eqf_pkg::CTR_TAP) ? m[17:0] : {6'h0, m[11:0]};
         end else if (tap_hit(wb_adr_i, eqf_pkg::OFF_SET_B)) begin
            m = wr_merge({14'h0, s_q.coef_b[t]}, wb_dat_i, wb_sel_i);
            s_d.coef_b[t] = (t == eqf_pkg::CTR_TAP) ? m[17:0] : {6'h0, m[11:0]};
         end
      end
      // reload only when empty or being read, so a stalled pair stands still
      if (fifo_pop) begin
         s_d.out_vld = 1'b1;
         s_d.out_dat = fifo_dat;
      end else if (tl_rdy_i) begin
         s_d.out_vld = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q        <= '0;
         s_q.ctrl   <= eqf_pkg::CTRL_RST;
         s_q.coef_a <= eqf_pkg::CSET_RST;
         s_q.coef_b <= eqf_pkg::CSET_RST;
         s_q.in_rdy <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o  = s_q.rdat;
   assign wb_ack_o  = s_q.ack;
   assign smp_rdy_o = s_q.in_rdy;
   assign tl_vld_o  = s_q.out_vld;
   assign tl_dat_o  = s_q.out_dat;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // the identity checks fire only while unity or zero sets are loaded

   bus_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   tl_hold_a: assert property (tl_vld_o && !tl_rdy_i |=> tl_vld_o && $stable(tl_dat_o))
      else $error("transport output changed while stalled");
   sample_gap_a: assert property (accept |=> !smp_rdy_o)
      else $error("second sample taken while result pending");
   mode_decode_a: assert property (active |-> s_q.ctrl.mode == 2'h2)
      else $error("filter active with wrong mode value");
   tv_gate_a: assert property (mode_on && !s_q.ctrl.share && s_q.ctrl.merge
      && !(s_q.ctrl.link_single && !s_q.ctrl.single_input) |-> !active)
      else $error("time-varying filter outside dual-input single channel");
   wsel_range_a: assert property (s_q.ctrl.wsel <= 3'h6)
      else $error("weight select out of range");
   center_wr_a: assert property (bus_go && wb_we_i && wb_sel_i == 4'hf
      && wb_adr_i == 8'h50 |=> s_q.coef_a[4] == $past(wb_dat_i[17:0]))
      else $error("center tap did not store 18 bits");
   nc_wr_a: assert property (bus_go && wb_we_i && wb_adr_i == 8'h80
      |=> s_q.coef_b[0][17:12] == 6'h0)
      else $error("non-center tap kept more than 12 bits");
   pass_thru_a: assert property (push && !active |-> push_dat == s_q.raw)
      else $error("disabled filter altered the sample");
   dual_ident_a: assert property (push && dual_eq && s_q.coef_a == eqf_pkg::CSET_RST
      && s_q.coef_b == eqf_pkg::CSET_RST |-> push_dat.a == s_q.ha[4]
      && push_dat.b == s_q.hb[4])
      else $error("unity filter not centered in dual mode");
   single_ident_a: assert property (push && single_eq && s_q.coef_a == eqf_pkg::CSET_RST
      |-> push_dat.a == s_q.hm[5] && push_dat.b == s_q.hm[4])
      else $error("unity filter not centered in single mode");
   tv_alt_a: assert property (push && tv_eq && s_q.coef_a == eqf_pkg::CSET_RST
      && s_q.coef_b == '0 |-> push_dat.a == s_q.hm[5] && push_dat.b == 8'h00)
      else $error("time-varying sets not alternated");
   rdat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero between answers");
   ack_follow_a: assert property (bus_go |=> wb_ack_o)
      else $error("bus request not answered in the next cycle");
   rdy_reopen_a: assert property (push |=> smp_rdy_o)
      else $error("sample input not reopened after a push");
   full_hold_a: assert property (s_q.pend && !fifo_in_rdy |=> !smp_rdy_o)
      else $error("sample taken while fifo full");
   out_load_a: assert property (fifo_pop
      |=> tl_vld_o && tl_dat_o == $past(fifo_dat))
      else $error("output register missed a fifo word");
   stat_full_a: assert property (bus_go && !wb_we_i && wb_adr_i == eqf_pkg::OFF_STAT
      |=> wb_dat_o[eqf_pkg::STAT_FULL] == !$past(fifo_in_rdy))
      else $error("status full bit wrong");
   off_stat_a: assert property (bus_go && !wb_we_i && wb_adr_i == eqf_pkg::OFF_STAT
      && !mode_on |=> wb_dat_o[1:0] == 2'h0)
      else $error("status shows a filter while mode is off");
   unmapped_rd_a: assert property (bus_go && !wb_we_i && wb_adr_i == 8'h30
      |=> wb_dat_o == 32'h0)
      else $error("unmapped read returned data");
   wsel_clamp_a: assert property (bus_go && wb_we_i && wb_adr_i == eqf_pkg::OFF_CTRL
      && wb_sel_i[0] && wb_dat_i[6:4] == 3'h7 |=> s_q.ctrl.wsel == 3'h6)
      else $error("weight select above range not clamped");

   dual_run_c: cover property (push && dual_eq);
   single_run_c: cover property (push && single_eq);
   tv_run_c: cover property (push && tv_eq);
   fifo_full_c: cover property (!fifo_in_rdy);
   illegal_mode_c: cover property (mode_on && !active);
endmodule

// *** testbench/eqf_far_model.sv ***
/*
 * far side of the equalizer: converter sample source and transport sink.
 * assumes eqf_top samples both handshakes on rising edges of clk_i.
 */
`timescale 1ns/1ps
module eqf_far_model (
   input  wire logic               clk_i,     // system clock
   input  wire logic               smp_rdy_i, // block takes a pair
   input  wire logic               tl_vld_i,  // block offers a pair
   input  wire eqf_pkg::eqf_samp_t tl_dat_i,  // offered pair
   input  wire logic               stall_i,   // hold transport ready low
   output logic                    smp_vld_o, // pair valid
   output eqf_pkg::eqf_samp_t      smp_o,     // pair to the block
   output logic                    tl_rdy_o   // transport ready
);
   eqf_pkg::eqf_samp_t got[$];
   eqf_pkg::eqf_samp_t pay;
   logic [15:0]        tick;

   // ==========================================================
   // sink
   initial begin
      smp_vld_o = 1'b0;
      tl_rdy_o  = 1'b0;
      pay       = 16'h0000;
      tick      = 16'h0000;
   end
   // idle data wanders so a stale pair is never mistaken for a fresh one
   assign smp_o = smp_vld_o ? pay : pay ^ ~tick;
   // ready drops one cycle in four so the fifo also meets a slow reader
   always @(posedge clk_i) begin
      tick     <= tick + 16'h0001;
      tl_rdy_o <= !stall_i && (tick[1:0] != 2'h0);
      if (tl_vld_i && tl_rdy_o)
         got.push_back(tl_dat_i);
   end

   // ==========================================================
   // source
   task automatic send(input eqf_pkg::eqf_samp_t p, output bit ok);
      int n;
      pay       <= p;
      smp_vld_o <= 1'b1;
      ok = 1'b0;
      for (n = 0; n < 200 && !ok; n++) begin
         @(posedge clk_i);
         ok = smp_rdy_i;
      end
      smp_vld_o <= 1'b0;
      @(posedge clk_i);
   endtask
endmodule

// *** testbench/eqf_top_tb.sv ***
/*
 * self-checking bench of eqf_top: register bus, sample stream in every filter
 * setting, output fifo back-pressure. assumes eqf_far_model on the stream side.
 */
`timescale 1ns/1ps
module eqf_top_tb;
   logic               clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
   logic               smp_vld, smp_rdy, tl_vld, tl_rdy, stall;
   logic [7:0]         wb_adr;
   logic [31:0]        wb_wdat, wb_rdat;
   eqf_pkg::eqf_samp_t smp, tl_dat;
   int                 errors, comparisons, md, ws, ca[9], cb[9], ha[9], hb[9], hm[9];
   logic [15:0]        exp_q[$];

   eqf_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .smp_vld_i(smp_vld), .smp_rdy_o(smp_rdy),
      .smp_i(smp), .tl_vld_o(tl_vld), .tl_rdy_i(tl_rdy), .tl_dat_o(tl_dat));
   eqf_far_model far (.clk_i(clk_i), .smp_rdy_i(smp_rdy), .tl_vld_i(tl_vld),
      .tl_dat_i(tl_dat), .stall_i(stall), .smp_vld_o(smp_vld), .smp_o(smp), .tl_rdy_o(tl_rdy));

   // ==========================================================
   // checking and bus
   task automatic end_of_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic hang(input string what);
      errors++;
      $display("unexpected %s expected completion seen timeout", what);
      end_of_test;
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= we;
      wb_adr  <= a;
      wb_wdat <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (wb_ack === 1'b1)
            break;
      end
      if (n == 20)
         hang("wb_ack_o");
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk("wb_dat_o", e, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   // ==========================================================
   // reference filter: weights in units of 2^-16, floor then saturate
   function automatic int fir(input int h[9], input int c[9]);
      longint s = 0;
      for (int k = 0; k < 9; k++)
         s += longint'(h[k]) * (k == 4 ? c[k] : c[k] * (1 << (6 - ws)));
      s = s >>> 16;
      return s > 127 ? 127 : (s < -128 ? -128 : int'(s));
   endfunction
   function automatic void shove(ref int h[9], input int x);
      for (int k = 8; k > 0; k--)
         h[k] = h[k - 1];
      h[0] = x;
   endfunction
   function automatic logic [31:0] cw(input int sh, me, w, ln, si);
      return 32'(eqf_pkg::MODE_ON) | 32'(sh) << eqf_pkg::CTRL_SHARE
         | 32'(me) << eqf_pkg::CTRL_MERGE | 32'(w) << eqf_pkg::CTRL_WSEL_LSB
         | 32'(ln) << eqf_pkg::CTRL_LINK_SC | 32'(si) << eqf_pkg::CTRL_SGL_IN;
   endfunction
   task automatic put(input int a, input int b);
      int ra, rb;
      bit ok;
      shove(ha, a);
      shove(hb, b);
      shove(hm, a);
      ra = fir(hm, ca);
      shove(hm, b);
      rb = fir(hm, cb);
      if (md == 2)
         rb = fir(hm, ca);
      if (md == 1) begin
         ra = fir(ha, ca);
         rb = fir(hb, cb);
      end
      if (md == 0) begin
         ra = a;
         rb = b;
      end
      exp_q.push_back({ra[7:0], rb[7:0]});
      far.send({a[7:0], b[7:0]}, ok);
      if (!ok)
         hang("smp_rdy_o");
   endtask
   task automatic drain(input bit cmp);
      int n;
      for (n = 0; n < 600 && far.got.size() < exp_q.size(); n++)
         @(posedge clk_i);
      if (far.got.size() != exp_q.size())
         hang("tl_vld_o");
      for (n = 0; cmp && n < exp_q.size(); n++)
         chk("tl_dat_o", 32'(exp_q[n]), 32'(far.got[n]));
      exp_q.delete();
      far.got.delete();
   endtask
   task automatic run(input int n, input int o);
      for (int i = 0; i < n; i++)
         put(((i * 53 + o) % 256) - 128, ((i * 29 + 3 * o) % 256) - 128);
   endtask
   // zero pairs flush every history so stale samples cannot leak across settings
   task automatic mode(input int m, input logic [31:0] w);
      wr(eqf_pkg::OFF_CTRL, w);
      md = m;
      ws = int'(w[6:4]);
      run(0, 0);
      for (int i = 0; i < 10; i++)
         put(0, 0);
      drain(1'b0);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      chk("tl_vld_o", 32'h0, 32'(tl_vld));
      rd(eqf_pkg::OFF_CTRL, 32'h0);
      rd(eqf_pkg::OFF_SET_A + 8'h10, 32'h10000);
      rd(eqf_pkg::OFF_SET_B + 8'h10, 32'h10000);
      rd(eqf_pkg::OFF_SET_B, 32'h0);
      wr(8'h30, 32'hffffffff);
      rd(8'h30, 32'h0);
      run(4, 1);
      drain(1'b1);
      rd(eqf_pkg::OFF_STAT, 32'h0);
      // unity sets out of reset, then set b zeroed for the time-varying case
      ca[4] = 65536;
      cb[4] = 65536;
      mode(1, cw(0, 0, 0, 0, 0));
      run(4, 2);
      drain(1'b1);
      mode(2, cw(1, 1, 0, 1, 1));
      run(4, 3);
      drain(1'b1);
      wr(eqf_pkg::OFF_SET_B + 8'h10, 32'h0);
      cb[4] = 0;
      mode(3, cw(0, 1, 0, 1, 0));
      run(4, 4);
      drain(1'b1);
      $display("test reset done");
   endtask
   task automatic t_coef;
      wr(eqf_pkg::OFF_SET_A, 32'hffffffff);
      rd(eqf_pkg::OFF_SET_A, 32'h00000fff);
      wr(eqf_pkg::OFF_SET_B + 8'h10, 32'hffffffff);
      rd(eqf_pkg::OFF_SET_B + 8'h10, 32'h0003ffff);
      for (int k = 0; k < 9; k++) begin
         ca[k] = k == 4 ? 40000 : (k * 517 % 4096) - 2048;
         cb[k] = k == 4 ? -70000 : 1900 - k * 450;
         wr(eqf_pkg::OFF_SET_A + 8'(4 * k), 32'(ca[k]) & (k == 4 ? 32'h3ffff : 32'hfff));
         wr(eqf_pkg::OFF_SET_B + 8'(4 * k), 32'(cb[k]) & (k == 4 ? 32'h3ffff : 32'hfff));
         rd(eqf_pkg::OFF_SET_A + 8'(4 * k), 32'(ca[k]) & (k == 4 ? 32'h3ffff : 32'hfff));
         rd(eqf_pkg::OFF_SET_B + 8'(4 * k), 32'(cb[k]) & (k == 4 ? 32'h3ffff : 32'hfff));
      end
      wr(eqf_pkg::OFF_CTRL, cw(0, 0, 7, 0, 0));
      rd(eqf_pkg::OFF_CTRL, cw(0, 0, 6, 0, 0));
      $display("test coefficients done");
   endtask
   task automatic t_modes;
      mode(0, 32'h0);
      run(12, 5);
      drain(1'b1);
      mode(1, cw(0, 0, 3, 0, 0));
      run(14, 7);
      drain(1'b1);
      for (int w = 0; w < 7; w++) begin
         mode(1, cw(0, 0, w, 0, 0));
         run(4, w + 9);
         drain(1'b1);
      end
      mode(2, cw(1, 1, 2, 1, 1));
      run(12, 11);
      drain(1'b1);
      mode(3, cw(0, 1, 5, 1, 0));
      run(12, 13);
      drain(1'b1);
      mode(0, cw(0, 1, 5, 0, 0));
      rd(eqf_pkg::OFF_STAT, 32'h2);
      run(6, 15);
      drain(1'b1);
      $display("test filter settings done");
   endtask
   task automatic t_full;
      mode(1, cw(0, 0, 0, 0, 0));
      stall <= 1'b1;
      repeat (2) @(posedge clk_i);
      // one pair in the output register, sixteen in the fifo, one left pending
      run(eqf_pkg::FIFO_DEPTH + 2, 17);
      repeat (4) @(posedge clk_i);
      chk("smp_rdy_o", 32'h0, 32'(smp_rdy));
      rd(eqf_pkg::OFF_STAT, 32'h5);
      stall <= 1'b0;
      drain(1'b1);
      $display("test fifo full done");
   endtask

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      rst_i   = 1'b1;
      wb_cyc  = 1'b0;
      wb_stb  = 1'b0;
      wb_we   = 1'b0;
      wb_adr  = 8'h00;
      wb_wdat = 32'h0;
      stall   = 1'b0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset;
      t_coef;
      t_modes;
      t_full;
      end_of_test;
   end
endmodule
